// ===== rtl/power_manager_pkg.sv
// Purpose: constants and types shared by the power manager register bank
// Assumes: 40 MHz system clock, byte-wide register space behind an I2C target
// Notes: 16-bit registers are little endian, low byte at the even offset
package power_manager_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int HOLD_MS = 2000;
  localparam logic [7:0] HOLD_TICKS = 8'(HOLD_MS / TICK_MS);
  localparam logic [6:0] PULSE_PERIOD = 7'h64;
  localparam logic [6:0] PULSE_HALF = 7'h32;
  localparam logic [6:0] FLASH_PERIOD = 7'h0a;
  localparam logic [6:0] FLASH_HALF = 7'h05;
  localparam int BASE_SHIFT = 4;

  localparam logic [7:0] OFS_VERSION = 8'h00;
  localparam logic [7:0] OFS_ADDRESS = 8'h01;
  localparam logic [7:0] OFS_LAMP_MODE = 8'h02;
  localparam logic [7:0] OFS_TOUCH_CYCLES = 8'h03;
  localparam logic [7:0] OFS_TOUCH_THRESH = 8'h04;
  localparam logic [7:0] OFS_TOUCH_HYST = 8'h05;
  localparam logic [7:0] OFS_RANGE_TRIM = 8'h06;
  localparam logic [7:0] OFS_STEP_TRIM = 8'h07;
  localparam logic [7:0] OFS_CUTOFF = 8'h08;
  localparam logic [7:0] OFS_SHUTDOWN = 8'h0a;
  localparam logic [7:0] OFS_BOOT = 8'h0c;
  localparam logic [7:0] OFS_WR_LAST = 8'h0d;
  localparam logic [7:0] OFS_BATTERY = 8'h32;
  localparam logic [7:0] OFS_OUTPUT = 8'h34;
  localparam logic [7:0] OFS_INPUT = 8'h36;
  localparam logic [7:0] OFS_CURRENT = 8'h38;
  localparam logic [7:0] OFS_BUTTON = 8'h3a;

  localparam logic [7:0] REG_SET_VERSION = 8'h07;
  localparam logic [7:0] RST_ADDRESS = 8'h43;
  localparam logic [7:0] RST_LAMP_MODE = 8'h01;
  localparam logic [7:0] RST_TOUCH_CYCLES = 8'h00;
  localparam logic [7:0] RST_TOUCH_THRESH = 8'h0c;
  localparam logic [7:0] RST_TOUCH_HYST = 8'h02;
  localparam logic [7:0] RST_RANGE_TRIM = 8'h00;
  localparam logic [7:0] RST_STEP_TRIM = 8'h00;
  localparam logic [15:0] RST_CUTOFF = 16'h1239;
  localparam logic [15:0] RST_SHUTDOWN = 16'h12dd;
  localparam logic [15:0] RST_BOOT = 16'h1424;
  localparam logic [7:0] UNLOCK_KEY = 8'hc9;
  localparam logic [7:0] UNMAPPED_BYTE = 8'hff;

  localparam logic [1:0] LAMP_OFF = 2'h0;
  localparam logic [1:0] LAMP_ON = 2'h1;
  localparam logic [1:0] LAMP_PULSE = 2'h2;
  localparam logic [1:0] LAMP_FLASH = 2'h3;

  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_REG = 2'h1;
  localparam logic [1:0] PH_UNLOCK = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;

  typedef enum logic [1:0] {
    HOST_OFF = 2'b00,
    HOST_BOOTING = 2'b01,
    HOST_ON = 2'b10,
    HOST_SHUTTING = 2'b11
  } host_e;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_RX = 3'b001,
    BUS_ACK = 3'b010,
    BUS_TX = 3'b011,
    BUS_RACK = 3'b100
  } bus_e;
endpackage : power_manager_pkg

// ===== rtl/power_manager_register_map.sv
// Purpose: I2C register bank and host power sequencer of a battery power manager
// Assumes: SCL and SDA_IN already synchronous to MCLK; readings are settled values
// Notes: SDA is open drain, SDA_OE high pulls the line low
//
// Overview of operation
// - address 0x00 reads the fixed register set version 0x07.
// - writable bus address register, default 0x43, selects the address answered.
// - host on: lamp mode 0 off, 1 steady, 2 pulsing, 3 fast flash.
// - otherwise lamp dark while off and pulsing while booting or shutting down.
// - button state reads zero when not pressed, nonzero while presses show.
// - low four bits are the last four samples, newest in bit zero.
// - button held two seconds asks the host to shut down; a press while off starts a boot.
// - touch cycle count zero selects mechanical switch, nonzero capacitive mode.
// - capacitive mode keeps a low-pass baseline following the touch reading.
// - touch on above baseline+threshold+hysteresis, off below baseline+threshold-hysteresis.
// - hysteresis, default two, added or subtracted by current touch state.
// - two writable oscillator trim bytes drive the clock calibration outputs.
// - input voltage reading is read-only 13 bits, little endian at 0x36.
// - battery voltage reading is read-only 13 bits, little endian at 0x32.
// - output voltage reading is read-only 13 bits, little endian at 0x34.
// - load current reading is read-only 13 bits, little endian at 0x38.
// - battery below cutoff threshold removes host power at once.
// - battery at or below shutdown threshold asks the host to shut down.
// - boot allowed only when battery reaches the boot threshold.
// - persistent registers are saved to flash after a write transfer.
// - data writes need unlock byte (address<<1)^0xC9^register, else not-acknowledge.
// - register pointer advances by one after each byte read or written.
// - reads outside defined registers return 0xFF.
// - writes outside writable registers are refused with not-acknowledge.
module power_manager_register_map
  import power_manager_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic BUTTON_PRESSED,
  input wire logic [15:0] TOUCH_READING,
  input wire logic TOUCH_READY,
  input wire logic [12:0] BATTERY_READING,
  input wire logic [12:0] OUTPUT_READING,
  input wire logic [12:0] INPUT_READING,
  input wire logic [12:0] CURRENT_READING,
  input wire logic HOST_RUNNING,
  input wire logic HOST_HALTED,
  output logic HOST_POWER,
  output logic SHUTDOWN_REQUEST,
  output logic POWER_LAMP,
  output logic [7:0] TOUCH_CYCLES,
  output logic [7:0] OSC_RANGE_TRIM,
  output logic [7:0] OSC_STEP_TRIM,
  output logic FLASH_SAVE
);
  typedef struct packed {
    host_e host;
    bus_e bus;
    logic [7:0] addr;
    logic [7:0] lamp_mode;
    logic [7:0] cycles;
    logic [7:0] thresh;
    logic [7:0] hyst;
    logic [7:0] trim_r;
    logic [7:0] trim_s;
    logic [15:0] vmin;
    logic [15:0] vshdn;
    logic [15:0] vboot;
    logic [7:0] ptr;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic [1:0] phase;
    logic rw;
    logic nack;
    logic dirty;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic [18:0] tick_cnt;
    logic tick;
    logic [3:0] hist;
    logic [7:0] hold;
    logic [6:0] blink;
    logic lamp;
    logic [15:0] base;
    logic touch;
    logic host_power;
    logic shdn_req;
    logic flash_save;
  } state_s;

  state_s s;
  state_s next_s;

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] rbyte;
    logic [7:0] key;
    logic sample;
    logic pulse;
    logic fast;
    logic [17:0] on_lvl;
    logic [17:0] off_lvl;
    logic [17:0] base_thr;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    rbyte = UNMAPPED_BYTE;
    key = 8'h00;
    sample = 1'b0;
    pulse = 1'b0;
    fast = 1'b0;
    on_lvl = 18'h0;
    off_lvl = 18'h0;
    base_thr = 18'h0;
    next_s = s;
    next_s.scl_q = SCL;
    next_s.sda_q = SDA_IN;
    next_s.flash_save = 1'b0;
    next_s.tick = 1'b0;

    scl_rise = SCL & ~s.scl_q;
    scl_fall = ~SCL & s.scl_q;
    start = s.scl_q & SCL & s.sda_q & ~SDA_IN;
    stop = s.scl_q & SCL & ~s.sda_q & SDA_IN;

    case (s.ptr)
      OFS_VERSION: rbyte = REG_SET_VERSION;
      OFS_ADDRESS: rbyte = s.addr;
      OFS_LAMP_MODE: rbyte = s.lamp_mode;
      OFS_TOUCH_CYCLES: rbyte = s.cycles;
      OFS_TOUCH_THRESH: rbyte = s.thresh;
      OFS_TOUCH_HYST: rbyte = s.hyst;
      OFS_RANGE_TRIM: rbyte = s.trim_r;
      OFS_STEP_TRIM: rbyte = s.trim_s;
      OFS_CUTOFF: rbyte = s.vmin[7:0];
      OFS_CUTOFF + 8'h01: rbyte = s.vmin[15:8];
      OFS_SHUTDOWN: rbyte = s.vshdn[7:0];
      OFS_SHUTDOWN + 8'h01: rbyte = s.vshdn[15:8];
      OFS_BOOT: rbyte = s.vboot[7:0];
      OFS_BOOT + 8'h01: rbyte = s.vboot[15:8];
      OFS_BATTERY: rbyte = BATTERY_READING[7:0];
      OFS_BATTERY + 8'h01: rbyte = {3'h0, BATTERY_READING[12:8]};
      OFS_OUTPUT: rbyte = OUTPUT_READING[7:0];
      OFS_OUTPUT + 8'h01: rbyte = {3'h0, OUTPUT_READING[12:8]};
      OFS_INPUT: rbyte = INPUT_READING[7:0];
      OFS_INPUT + 8'h01: rbyte = {3'h0, INPUT_READING[12:8]};
      OFS_CURRENT: rbyte = CURRENT_READING[7:0];
      OFS_CURRENT + 8'h01: rbyte = {3'h0, CURRENT_READING[12:8]};
      OFS_BUTTON: rbyte = {4'h0, s.hist};
      default: rbyte = UNMAPPED_BYTE;
    endcase
    key = {s.addr[6:0], 1'b0} ^ UNLOCK_KEY ^ s.ptr;

    case (s.bus)
      BUS_IDLE: begin
        next_s.sda_oe = 1'b0;
      end
      BUS_RX: begin
        if (scl_rise) begin
          next_s.shift = {s.shift[6:0], SDA_IN};
          next_s.cnt = s.cnt + 4'h1;
        end
        if (scl_fall && s.cnt == 4'h8) begin
          next_s.bus = BUS_ACK;
          next_s.nack = 1'b0;
          case (s.phase)
            PH_ADDR: begin
              if (s.shift[7:1] == s.addr[6:0]) begin
                next_s.rw = s.shift[0];
              end else begin
                next_s.bus = BUS_IDLE;
              end
            end
            PH_REG: next_s.ptr = s.shift;
            PH_UNLOCK: next_s.nack = (s.shift != key);
            default: begin
              if (s.ptr >= OFS_ADDRESS && s.ptr <= OFS_WR_LAST) begin
                next_s.ptr = s.ptr + 8'h01;
                next_s.dirty = 1'b1;
                case (s.ptr)
                  OFS_ADDRESS: next_s.addr = s.shift;
                  OFS_LAMP_MODE: next_s.lamp_mode = s.shift;
                  OFS_TOUCH_CYCLES: next_s.cycles = s.shift;
                  OFS_TOUCH_THRESH: next_s.thresh = s.shift;
                  OFS_TOUCH_HYST: next_s.hyst = s.shift;
                  OFS_RANGE_TRIM: next_s.trim_r = s.shift;
                  OFS_STEP_TRIM: next_s.trim_s = s.shift;
                  OFS_CUTOFF: next_s.vmin[7:0] = s.shift;
                  OFS_CUTOFF + 8'h01: next_s.vmin[15:8] = s.shift;
                  OFS_SHUTDOWN: next_s.vshdn[7:0] = s.shift;
                  OFS_SHUTDOWN + 8'h01: next_s.vshdn[15:8] = s.shift;
                  OFS_BOOT: next_s.vboot[7:0] = s.shift;
                  default: next_s.vboot[15:8] = s.shift;
                endcase
              end else begin
                next_s.nack = 1'b1;
              end
            end
          endcase
          next_s.sda_oe = (next_s.bus == BUS_ACK) & ~next_s.nack;
        end
      end
      BUS_ACK: begin
        if (scl_fall) begin
          next_s.sda_oe = 1'b0;
          next_s.cnt = 4'h0;
          if (s.nack) begin
            next_s.bus = BUS_IDLE;
          end else if (s.phase == PH_ADDR && s.rw) begin
            next_s.bus = BUS_TX;
            next_s.shift = rbyte;
            next_s.sda_oe = ~rbyte[7];
          end else begin
            next_s.bus = BUS_RX;
            next_s.phase = (s.phase == PH_DATA) ? PH_DATA : s.phase + 2'h1;
          end
        end
      end
      BUS_TX: begin
        if (scl_rise) begin
          next_s.cnt = s.cnt + 4'h1;
        end
        if (scl_fall) begin
          if (s.cnt == 4'h8) begin
            next_s.sda_oe = 1'b0;
            next_s.bus = BUS_RACK;
            next_s.ptr = s.ptr + 8'h01;
          end else begin
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.sda_oe = ~s.shift[6];
          end
        end
      end
      BUS_RACK: begin
        if (scl_rise) begin
          next_s.nack = SDA_IN;
        end
        if (scl_fall) begin
          next_s.cnt = 4'h0;
          if (s.nack) begin
            next_s.bus = BUS_IDLE;
          end else begin
            next_s.bus = BUS_TX;
            next_s.shift = rbyte;
            next_s.sda_oe = ~rbyte[7];
          end
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
        next_s.sda_oe = 1'b0;
      end
    endcase
    // a repeated start may arrive in any state, so it overrides the byte engine
    if (start) begin
      next_s.bus = BUS_RX;
      next_s.cnt = 4'h0;
      next_s.phase = PH_ADDR;
      next_s.sda_oe = 1'b0;
    end else if (stop) begin
      next_s.bus = BUS_IDLE;
      next_s.sda_oe = 1'b0;
      // one flash save per transfer keeps wear down
      next_s.flash_save = s.dirty;
      next_s.dirty = 1'b0;
    end

    if (s.tick_cnt == 19'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = 19'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 19'h1;
    end

    base_thr = {2'h0, s.base} + {10'h0, s.thresh};
    on_lvl = base_thr + {10'h0, s.hyst};
    off_lvl = (base_thr > {10'h0, s.hyst}) ? base_thr - {10'h0, s.hyst} : 18'h0;
    if (TOUCH_READY && s.cycles != 8'h00) begin
      if (TOUCH_READING > s.base) begin
        next_s.base = s.base + ((TOUCH_READING - s.base) >> BASE_SHIFT);
      end else begin
        next_s.base = s.base - ((s.base - TOUCH_READING) >> BASE_SHIFT);
      end
      if (!s.touch && {2'h0, TOUCH_READING} > on_lvl) begin
        next_s.touch = 1'b1;
      end else if (s.touch && {2'h0, TOUCH_READING} < off_lvl) begin
        next_s.touch = 1'b0;
      end
    end
    sample = (s.cycles == 8'h00) ? BUTTON_PRESSED : s.touch;

    if (s.tick) begin
      next_s.hist = {s.hist[2:0], sample};
      if (!sample) begin
        next_s.hold = 8'h00;
      end else if (s.hold != HOLD_TICKS) begin
        next_s.hold = s.hold + 8'h01;
      end
      next_s.blink = (s.blink == PULSE_PERIOD - 7'h01) ? 7'h00 : s.blink + 7'h01;
    end

    case (s.host)
      HOST_OFF: begin
        if (s.hist == 4'h1 && {3'h0, BATTERY_READING} >= s.vboot) begin
          next_s.host = HOST_BOOTING;
        end
      end
      HOST_BOOTING: begin
        if (HOST_RUNNING) begin
          next_s.host = HOST_ON;
        end
      end
      HOST_ON: begin
        if ({3'h0, BATTERY_READING} <= s.vshdn) begin
          next_s.host = HOST_SHUTTING;
        end else if (s.hold == HOLD_TICKS) begin
          next_s.host = HOST_SHUTTING;
        end
      end
      HOST_SHUTTING: begin
        if (HOST_HALTED) begin
          next_s.host = HOST_OFF;
        end
      end
      default: next_s.host = HOST_OFF;
    endcase
    if ({3'h0, BATTERY_READING} < s.vmin) begin
      next_s.host = HOST_OFF;
    end
    next_s.host_power = (next_s.host != HOST_OFF);
    next_s.shdn_req = (next_s.host == HOST_SHUTTING);

    pulse = (s.blink < PULSE_HALF);
    fast = ((s.blink % FLASH_PERIOD) < FLASH_HALF);
    case (s.host)
      HOST_ON: begin
        case (s.lamp_mode[1:0])
          LAMP_OFF: next_s.lamp = 1'b0;
          LAMP_ON: next_s.lamp = 1'b1;
          LAMP_PULSE: next_s.lamp = pulse;
          default: next_s.lamp = fast;
        endcase
      end
      HOST_BOOTING, HOST_SHUTTING: next_s.lamp = pulse;
      default: next_s.lamp = 1'b0;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      s <= '0;
      s.host <= HOST_OFF;
      s.bus <= BUS_IDLE;
      s.addr <= RST_ADDRESS;
      s.lamp_mode <= RST_LAMP_MODE;
      s.cycles <= RST_TOUCH_CYCLES;
      s.thresh <= RST_TOUCH_THRESH;
      s.hyst <= RST_TOUCH_HYST;
      s.trim_r <= RST_RANGE_TRIM;
      s.trim_s <= RST_STEP_TRIM;
      s.vmin <= RST_CUTOFF;
      s.vshdn <= RST_SHUTDOWN;
      s.vboot <= RST_BOOT;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign SDA_OUT = 1'b0;
  assign SDA_OE = s.sda_oe;
  assign HOST_POWER = s.host_power;
  assign SHUTDOWN_REQUEST = s.shdn_req;
  assign POWER_LAMP = s.lamp;
  assign TOUCH_CYCLES = s.cycles;
  assign OSC_RANGE_TRIM = s.trim_r;
  assign OSC_STEP_TRIM = s.trim_s;
  assign FLASH_SAVE = s.flash_save;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);

  sequence bad_unlock_s;
    s.bus == BUS_RX && s.phase == PH_UNLOCK && s.cnt == 4'h8 && !SCL && s.scl_q
      && s.shift != ({s.addr[6:0], 1'b0} ^ UNLOCK_KEY ^ s.ptr);
  endsequence
  sequence refused_s;
    s.bus == BUS_ACK && s.nack;
  endsequence

  a_cutoff_power: assert property (
    {3'h0, BATTERY_READING} < s.vmin |=> !HOST_POWER)
    else $error("host power kept below cutoff");
  a_boot_gate: assert property (
    $rose(HOST_POWER) |-> {3'h0, $past(BATTERY_READING)} >= $past(s.vboot))
    else $error("host booted below boot threshold");
  a_shutdown_request: assert property (
    s.host == HOST_ON && {3'h0, BATTERY_READING} <= s.vshdn
      && {3'h0, BATTERY_READING} >= s.vmin |=> SHUTDOWN_REQUEST)
    else $error("no shutdown request at threshold");
  a_lamp_dark_off: assert property (
    s.host == HOST_OFF && $past(s.host) == HOST_OFF |-> !POWER_LAMP)
    else $error("lamp lit while host off");
  a_lamp_mode_on: assert property (
    s.host == HOST_ON && s.lamp_mode[1:0] == LAMP_ON |=> POWER_LAMP || s.host != HOST_ON)
    else $error("steady lamp mode not lit");
  a_hold_turns_off: assert property (
    s.host == HOST_ON && s.hold == HOLD_TICKS |=> s.host == HOST_SHUTTING || s.host == HOST_OFF)
    else $error("long press did not end host on state");
  a_hist_shift: assert property (
    s.tick && s.cycles == 8'h00 |=> s.hist == {$past(s.hist[2:0]), $past(BUTTON_PRESSED)})
    else $error("button history not shifted");
  a_unlock_nack: assert property (
    bad_unlock_s |=> refused_s ##0 !SDA_OE)
    else $error("wrong unlock byte acknowledged");
  a_write_refused: assert property (
    s.bus == BUS_RX && s.phase == PH_DATA && s.cnt == 4'h8 && !SCL && s.scl_q
      && (s.ptr == OFS_VERSION || s.ptr > OFS_WR_LAST) |=> refused_s ##1 $stable(s.ptr))
    else $error("write outside writable range not refused");
  a_touch_active: assert property (
    TOUCH_READY && s.cycles != 8'h00 && !s.touch
      && {2'h0, TOUCH_READING} > {2'h0, s.base} + {10'h0, s.thresh} + {10'h0, s.hyst}
      |=> s.touch)
    else $error("touch not detected above on level");
endmodule : power_manager_register_map

// ===== tb/i2c_host_model.sv
// Purpose: host side two-wire bus master for the register port
// Assumes: line pulled up, host never stretches the clock
// Notes: data moves only while the clock is low; 7 MCLK per bit
module i2c_host_model (
  input wire logic mclk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask : gap
  // one bit: set up while low, sampled late in the high phase
  task automatic slot(input logic b, output logic seen);
    sda_low = ~b;
    gap(3);
    scl = 1'b1;
    gap(3);
    seen = sda_wire;
    scl = 1'b0;
    gap(1);
  endtask : slot
  task automatic start();
    sda_low = 1'b0;
    gap(2);
    scl = 1'b1;
    gap(3);
    sda_low = 1'b1;
    gap(3);
    scl = 1'b0;
    gap(1);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    gap(2);
    scl = 1'b1;
    gap(3);
    sda_low = 1'b0;
    gap(3);
  endtask : stop
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(last, s);
  endtask : rbyte
endmodule : i2c_host_model

// ===== tb/tb_top.sv
// Purpose: self-checking bench of the power manager register bank
// Assumes: host model on the bus, readings and host status driven here
// Notes: short system tick keeps the two second hold inside the run
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import power_manager_pkg::*;
  localparam int TICK = 100;
  localparam logic [7:0] AW = {RST_ADDRESS[6:0], 1'b0};
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic button = 1'b0;
  logic touch_rdy = 1'b0;
  logic running = 1'b0;
  logic halted = 1'b0;
  logic [15:0] touch_rd = '0;
  logic [12:0] bat = 13'h1770;
  logic [12:0] output_voltage_reading_r = '0;
  logic [12:0] vin_r = '0;
  logic [12:0] cur_r = '0;
  logic host_power, shut_req, lamp, fsave, sda_out, sda_oe, scl, sda_low, sda_wire;
  logic [7:0] touch_cyc, rtrim, strim, v;
  int mem [256];
  int n_mismatch = 0;
  int checked = 0;
  int saves = 0;
  int boot;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (fsave === 1'b1) saves++;
  // open drain with pull-up: any party pulling wins
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
  i2c_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  power_manager_register_map #(.TICK_CYCLES(TICK)) dut (
    .MCLK(mclk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .BUTTON_PRESSED(button), .TOUCH_READING(touch_rd),
    .TOUCH_READY(touch_rdy), .BATTERY_READING(bat), .OUTPUT_READING(output_voltage_reading_r),
    .INPUT_READING(vin_r), .CURRENT_READING(cur_r), .HOST_RUNNING(running),
    .HOST_HALTED(halted), .HOST_POWER(host_power), .SHUTDOWN_REQUEST(shut_req),
    .POWER_LAMP(lamp), .TOUCH_CYCLES(touch_cyc), .OSC_RANGE_TRIM(rtrim),
    .OSC_STEP_TRIM(strim), .FLASH_SAVE(fsave));
  function automatic logic [7:0] exp_rd(input int a);
    logic [15:0] r;
    case (a & 'hfe)
      'h32: r = 16'(bat);
      'h34: r = 16'(output_voltage_reading_r);
      'h36: r = 16'(vin_r);
      'h38: r = 16'(cur_r);
      default: return 8'(mem[a]);
    endcase
    return a[0] ? r[15:8] : r[7:0];
  endfunction : exp_rd
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  task automatic chk_flag(input string what, input logic e, input logic g);
    chk_byte(what, {7'h00, e}, {7'h00, g});
  endtask : chk_flag
  task automatic chk_count(input string what, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
    end
  endtask : chk_count
  task automatic ticks(input int n);
    repeat (n * TICK) @(negedge mclk);
  endtask : ticks
  task automatic press(input int n);
    button = 1'b1;
    ticks(n);
    button = 1'b0;
  endtask : press
  task automatic touch(input logic [15:0] r, input int n);
    repeat (n) begin
      @(negedge mclk);
      touch_rd = r;
      touch_rdy = 1'b1;
      @(negedge mclk);
      touch_rdy = 1'b0;
    end
  endtask : touch
  task automatic lit(input int n, input int e, input string what);
    int c;
    c = 0;
    repeat (n) begin
      @(negedge mclk);
      if (lamp === 1'b1) c++;
    end
    chk_count(what, e, c);
  endtask : lit
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$], input logic bad);
    logic ack;
    int hit;
    int s0;
    hit = 0;
    host.start();
    host.wbyte(AW, ack);
    host.wbyte(a, ack);
    host.wbyte(AW ^ UNLOCK_KEY ^ a ^ {8{bad}}, ack);
    chk_flag("unlock ack", !bad, ack);
    for (int i = 0; i < d.size() && ack; i++) begin
      host.wbyte(d[i], ack);
      chk_flag("data ack", a + i > 0 && a + i <= 'h0d, ack);
      if (ack === 1'b1) begin
        mem[a + i] = d[i];
        hit = 1;
      end
    end
    s0 = saves;
    host.stop();
    repeat (5) @(negedge mclk);
    if (hit == 1) chk_count("flash saves", s0 + 1, saves);
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] b);
    logic ack;
    host.start();
    host.wbyte(AW, ack);
    host.wbyte(a, ack);
    host.start();
    host.wbyte(AW | 8'h01, ack);
    chk_flag("address ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      if (a + i != OFS_BUTTON) chk_byte($sformatf("reg %h", a + i), exp_rd(a + i), b);
    end
    host.stop();
  endtask : rd
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    logic [7:0] q [$];
    int c;
    int w;
    void'($urandom(90457));
    foreach (mem[i]) mem[i] = 'hff;
    q = '{8'h07, 8'h43, 8'h01, 8'h00, 8'h0c, 8'h02, 8'h00, 8'h00, 8'h39, 8'h12, 8'hdd, 8'h12,
          8'h24, 8'h14};
    foreach (q[i]) mem[i] = q[i];
    mem['h3a] = 0;
    output_voltage_reading_r = 13'($urandom);
    vin_r = 13'($urandom);
    cur_r = 13'($urandom);
    repeat (16) @(negedge mclk);
    chk_byte("reset outputs", 8'h00, {3'h0, host_power, shut_req, lamp, fsave, sda_oe});
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    rd(8'h00, 16, v);
    rd(8'h30, 12, v);
    q = '{8'($urandom), 8'($urandom)};
    wr(OFS_RANGE_TRIM, q, 1'b0);
    chk_byte("range trim", q[0], rtrim);
    chk_byte("step trim", q[1], strim);
    wr(OFS_CUTOFF, '{8'h00}, 1'b1);
    wr(OFS_VERSION, '{8'h55}, 1'b0);
    wr(OFS_BOOT, '{8'h30, 8'h14, 8'h77}, 1'b0);
    rd(8'h06, 9, v);
    boot = mem[12] | mem[13] << 8;
    bat = 13'(boot - 1);
    press(3);
    ticks(6);
    chk_flag("boot refused", 1'b0, host_power);
    bat = 13'(boot);
    for (int ph = 0; ph < 2; ph++) begin
      button = (ph == 0);
      c = 0;
      do begin
        rd(OFS_BUTTON, 1, v);
        chk_flag("history", 1'b1, ph ? (v[3:0] inside {0, 8, 12, 14, 15})
                                     : (v[3:0] inside {0, 1, 3, 7, 15}));
        c++;
      end while (v[3:0] !== (ph ? 4'h0 : 4'hf) && c < 20);
    end
    chk_byte("button idle", 8'h00, v);
    chk_flag("boot at threshold", 1'b1, host_power);
    lit(100 * TICK, 50 * TICK, "booting lamp");
    running = 1'b1;
    for (int m = 0; m < 4; m++) begin
      w = (m == 2 ? 100 : 10) * TICK;
      wr(OFS_LAMP_MODE, '{8'(m)}, 1'b0);
      lit(w, m == 0 ? 0 : (m == 1 ? w : w / 2), "lamp mode");
    end
    wr(OFS_LAMP_MODE, '{8'h01}, 1'b0);
    button = 1'b1;
    c = 0;
    while (shut_req !== 1'b1 && c < 300 * TICK) begin
      @(negedge mclk);
      c++;
    end
    chk_flag("hold time", 1'b1, c >= 199 * TICK && c <= 202 * TICK);
    chk_flag("power kept", 1'b1, host_power);
    button = 1'b0;
    lit(100 * TICK, 50 * TICK, "shutdown lamp");
    halted = 1'b1;
    running = 1'b0;
    repeat (3) @(negedge mclk);
    chk_flag("host off", 1'b0, host_power);
    lit(10 * TICK, 0, "off lamp");
    halted = 1'b0;
    press(2);
    ticks(2);
    chk_flag("booted", 1'b1, host_power);
    running = 1'b1;
    bat = 13'((mem[10] | mem[11] << 8) + 1);
    ticks(1);
    chk_flag("above shutdown", 1'b0, shut_req);
    bat = bat - 13'h0001;
    repeat (3) @(negedge mclk);
    chk_flag("at shutdown", 1'b1, shut_req);
    bat = 13'((mem[8] | mem[9] << 8) - 1);
    repeat (2) @(negedge mclk);
    chk_flag("cutoff", 1'b0, host_power);
    bat = 13'(boot - 1);
    running = 1'b0;
    // threshold and hysteresis stay at defaults; only the mode changes
    wr(OFS_TOUCH_CYCLES, '{8'h14}, 1'b0);
    chk_byte("touch cycles", 8'h14, touch_cyc);
    q = '{8'h00, 8'h0f, 8'h0b, 8'h09, 8'h0d};
    foreach (q[i]) begin
      touch({8'h00, q[i]}, 1);
      ticks(6);
      rd(OFS_BUTTON, 1, v);
      chk_byte("touch", (i == 1 || i == 2) ? 8'h0f : 8'h00, {4'h0, v[3:0]});
    end
    touch(16'h00c8, 40);
    ticks(6);
    touch(16'h0014, 1);
    ticks(6);
    rd(OFS_BUTTON, 1, v);
    chk_byte("baseline", 8'h00, {4'h0, v[3:0]});
    end_sim();
  end
  initial begin
    // the scenarios need about 70k cycles; stay under the 95k run budget
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    end_sim();
  end
endmodule : tb_top
